// File: core/ses_event_set.sv
`timescale 1ns/1ns
module ses_event_set #(
  parameter logic [ses_pkg::REG_W-1:0] USED = ses_pkg::OPER_USED_MASK,
  parameter logic [ses_pkg::REG_W-1:0] RST_VAL = ses_pkg::EVT_RST
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  ses_evt_if.bank bus
);
  import ses_pkg::*;

  logic [REG_W-1:0] evt_ff;
  logic [REG_W-1:0] nxt_evt;
  logic [REG_W-1:0] en_ff;
  logic [REG_W-1:0] nxt_en;
  logic sum_ff;
  logic nxt_sum;

  always_comb begin
    nxt_evt = evt_ff;
    // [R20] clear on read
    if (bus.rd_clr || bus.cls) begin
      nxt_evt = EVT_RST;
    end
    // [R19] [R22] sticky set wins, unused masked
    nxt_evt = (nxt_evt | bus.set_vec) & USED;
    nxt_en = en_ff;
    if (bus.en_clr) begin
      nxt_en = EN_RST;
    end
    if (bus.en_wr) begin
      nxt_en = bus.en_data & USED;
    end
    // [R21] masked summary
    nxt_sum = |(nxt_evt & nxt_en);
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      evt_ff <= RST_VAL;
      en_ff <= EN_RST;
      sum_ff <= 1'b0;
    end else begin
      evt_ff <= nxt_evt;
      en_ff <= nxt_en;
      sum_ff <= nxt_sum;
    end
  end

  assign bus.evt = evt_ff;
  assign bus.en = en_ff;
  assign bus.summary = sum_ff;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_EVT_LATCH: assert property ((bus.set_vec & USED) != '0 |=> (evt_ff & $past(bus.set_vec & USED)) == $past(bus.set_vec & USED)) // [R19]
    else $error("event bit not latched");
  AST_EVT_HOLD: assert property (!bus.rd_clr && !bus.cls |=> (evt_ff & $past(evt_ff)) == $past(evt_ff)) // [R19]
    else $error("event bit dropped without clear");
  AST_READ_CLR: assert property (bus.rd_clr |=> (evt_ff & ~$past(bus.set_vec)) == '0) // [R20]
    else $error("read did not clear events");
  AST_SUMMARY: assert property (sum_ff == |(evt_ff & en_ff)) // [R21]
    else $error("summary mismatch");
  AST_UNUSED_EVT: assert property ((evt_ff & ~USED) == '0 && (en_ff & ~USED) == '0) // [R22]
    else $error("unused bit set");
  COV_SUMMARY: cover property ($rose(sum_ff));
endmodule // ses_event_set

// File: core/ses_status_top.sv
`timescale 1ns/1ns
// How it works
// [R1] operation-done bit sets only after the command, once nothing is pending
// [R2] reading from an empty output queue sets query error
// [R3] internal operation failure sets device-dependent error
// [R4] error while executing a command sets execution error
// [R5] syntax, semantic or trigger-in-message errors set command error
// [R6] local key press sets user request
// [R7] power cycle since last read sets power-on bit
// [R8] voltage protection per channel sets operation bit 1 or 2
// [R9] current-limit bits 3 and 7 follow the channel's limit state
// [R10] trip bits 4 and 8 set on trip, clear on output re-enable
// [R11] overheat shutdowns set operation bits 5 and 6
// [R12] reading overflow sets measurement bit 3 or 6
// [R13] missing current pulse sets measurement bit 4 or 7
// [R14] each processed reading sets measurement bit 5 or 8
// [R15] reaching the average count sets measurement bit 9 or 10
// [R16] bad calibration at power-up sets questionable bit 8 until calibrated
// [R17] live condition registers mirror state for three sets, none for standard
// [R18] battery pulse-timeout condition follows pulse detection directly
// [R19] event bits latch at one until cleared
// [R20] reading an event register or clear-status empties it
// [R21] enabled event bits OR into one summary per set
// [R22] unused positions always read zero
module ses_status_top (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire ses_pkg::ses_op_t cmd_op_i,
  input wire ses_pkg::ses_set_t cmd_set_i,
  input wire logic [ses_pkg::REG_W-1:0] cmd_data_i,
  input wire logic ops_pending_i,
  input wire logic query_empty_read_i,
  input wire logic device_fault_i,
  input wire logic exec_fault_i,
  input wire logic syntax_err_i,
  input wire logic semantic_err_i,
  input wire logic trigger_in_msg_i,
  input wire logic local_key_i,
  input wire logic battery_overvolt_protect_i,
  input wire logic charger_overvolt_protect_i,
  input wire logic battery_in_current_limit_i,
  input wire logic charger_in_current_limit_i,
  input wire logic battery_limit_trip_i,
  input wire logic charger_limit_trip_i,
  input wire logic battery_output_on_i,
  input wire logic charger_output_on_i,
  input wire logic output_stage_overheat_off_i,
  input wire logic main_supply_overheat_off_i,
  input wire logic battery_reading_overflow_i,
  input wire logic charger_reading_overflow_i,
  input wire logic battery_pulse_timeout_i,
  input wire logic charger_pulse_timeout_i,
  input wire logic battery_reading_ready_i,
  input wire logic charger_reading_ready_i,
  input wire logic battery_buffer_arm_i,
  input wire logic charger_buffer_arm_i,
  input wire logic [ses_pkg::AVG_CNT_W-1:0] battery_avg_count_i,
  input wire logic [ses_pkg::AVG_CNT_W-1:0] charger_avg_count_i,
  input wire logic cal_const_bad_i,
  input wire logic cal_done_ok_i,
  output logic rsp_valid_o,
  output logic [ses_pkg::REG_W-1:0] rsp_data_o,
  output logic std_summary_o,
  output logic oper_summary_o,
  output logic meas_summary_o,
  output logic ques_summary_o
);
  import ses_pkg::*;

  ses_evt_if std_if ();
  ses_evt_if oper_if ();
  ses_evt_if meas_if ();
  ses_evt_if ques_if ();

  ses_event_set #(.USED(STD_USED_MASK), .RST_VAL(STD_EVT_RST)) u_std (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .bus(std_if.bank)
  );
  ses_event_set #(.USED(OPER_USED_MASK), .RST_VAL(EVT_RST)) u_oper (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .bus(oper_if.bank)
  );
  ses_event_set #(.USED(MEAS_USED_MASK), .RST_VAL(EVT_RST)) u_meas (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .bus(meas_if.bank)
  );
  ses_event_set #(.USED(QUES_USED_MASK), .RST_VAL(EVT_RST)) u_ques (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .bus(ques_if.bank)
  );

  logic [N_CHAN-1:0] ch_trip;
  logic [N_CHAN-1:0] ch_on;
  logic [N_CHAN-1:0] ch_ready;
  logic [N_CHAN-1:0] ch_arm;
  logic [AVG_CNT_W-1:0] ch_avg [N_CHAN];
  logic [N_CHAN-1:0] tripped_ff;
  logic [N_CHAN-1:0] buf_full_ff;

  assign ch_trip = {charger_limit_trip_i, battery_limit_trip_i};
  assign ch_on = {charger_output_on_i, battery_output_on_i};
  assign ch_ready = {charger_reading_ready_i, battery_reading_ready_i};
  assign ch_arm = {charger_buffer_arm_i, battery_buffer_arm_i};
  assign ch_avg[CH_BAT] = battery_avg_count_i;
  assign ch_avg[CH_CHG] = charger_avg_count_i;

  // per-channel trip state and reading counter
  for (genvar c = 0; c < N_CHAN; c++) begin : g_chan
    logic nxt_trip;
    logic [AVG_CNT_W-1:0] cnt_ff;
    logic [AVG_CNT_W-1:0] nxt_cnt;
    logic [AVG_CNT_W-1:0] inc;
    logic nxt_full;
    always_comb begin
      // [R10] trip set wins re-enable
      nxt_trip = (tripped_ff[c] && !ch_on[c]) || ch_trip[c];
      inc = AVG_CNT_W'(cnt_ff + 1'b1);
      nxt_cnt = cnt_ff;
      nxt_full = buf_full_ff[c];
      // [R15] count to average
      if (ch_arm[c]) begin
        nxt_cnt = '0;
        nxt_full = 1'b0;
      end else if (ch_ready[c] && !buf_full_ff[c]) begin
        nxt_cnt = inc;
        nxt_full = (inc >= ch_avg[c]);
      end
    end
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        tripped_ff[c] <= 1'b0;
        cnt_ff <= '0;
        buf_full_ff[c] <= 1'b0;
      end else begin
        tripped_ff[c] <= nxt_trip;
        cnt_ff <= nxt_cnt;
        buf_full_ff[c] <= nxt_full;
      end
    end
  end

  ses_opc_state_t opc_state_ff;
  ses_opc_state_t nxt_opc_state;
  logic opc_set;
  logic init_done_ff;
  logic cal_bad_ff;
  logic nxt_cal_bad;
  logic [REG_W-1:0] oper_cond_ff;
  logic [REG_W-1:0] nxt_oper_cond;
  logic [REG_W-1:0] meas_cond_ff;
  logic [REG_W-1:0] nxt_meas_cond;
  logic [REG_W-1:0] ques_cond;
  logic [REG_W-1:0] ques_set;
  logic [REG_W-1:0] std_set;
  logic [REG_W-1:0] meas_pulse;
  logic rsp_valid_ff;
  logic nxt_rsp_valid;
  logic [REG_W-1:0] rsp_data_ff;
  logic [REG_W-1:0] nxt_rsp_data;
  logic is_cmd_cls;
  logic is_read_evt;

  always_comb begin
    nxt_opc_state = opc_state_ff;
    opc_set = 1'b0;
    // [R1] wait for idle
    unique case (opc_state_ff)
      OPC_IDLE: begin
        if (cmd_valid_i && cmd_op_i == OP_OPC) begin
          nxt_opc_state = OPC_WAIT;
        end
      end
      OPC_WAIT: begin
        if (is_cmd_cls) begin
          nxt_opc_state = OPC_IDLE;
        end else if (!ops_pending_i) begin
          opc_set = 1'b1;
          nxt_opc_state = OPC_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    // [R16] cal flag captured at start
    nxt_cal_bad = cal_bad_ff;
    if (!init_done_ff) begin
      nxt_cal_bad = cal_const_bad_i;
    end else if (cal_done_ok_i) begin
      nxt_cal_bad = 1'b0;
    end
    // [R17] live operation state
    nxt_oper_cond = COND_RST;
    // [R8] voltage protection
    nxt_oper_cond[OPER_BAT_VPROT] = battery_overvolt_protect_i;
    nxt_oper_cond[OPER_CHG_VPROT] = charger_overvolt_protect_i;
    // [R9] current limit level
    nxt_oper_cond[OPER_BAT_CLIM] = battery_in_current_limit_i;
    nxt_oper_cond[OPER_CHG_CLIM] = charger_in_current_limit_i;
    // [R10] tripped state
    nxt_oper_cond[OPER_BAT_TRIP] = g_chan[CH_BAT].nxt_trip;
    nxt_oper_cond[OPER_CHG_TRIP] = g_chan[CH_CHG].nxt_trip;
    // [R11] overheat shutdowns
    nxt_oper_cond[OPER_STAGE_HOT] = output_stage_overheat_off_i;
    nxt_oper_cond[OPER_SUPPLY_HOT] = main_supply_overheat_off_i;
    // [R17] live measurement state
    nxt_meas_cond = COND_RST;
    // [R12] overflow
    nxt_meas_cond[MEAS_BAT_OVF] = battery_reading_overflow_i;
    nxt_meas_cond[MEAS_CHG_OVF] = charger_reading_overflow_i;
    // [R13] [R18] pulse timeout level
    nxt_meas_cond[MEAS_BAT_PTO] = battery_pulse_timeout_i;
    nxt_meas_cond[MEAS_CHG_PTO] = charger_pulse_timeout_i;
    nxt_meas_cond[MEAS_BAT_RDY] = battery_reading_ready_i;
    nxt_meas_cond[MEAS_CHG_RDY] = charger_reading_ready_i;
    nxt_meas_cond[MEAS_BAT_BUF] = g_chan[CH_BAT].nxt_full;
    nxt_meas_cond[MEAS_CHG_BUF] = g_chan[CH_CHG].nxt_full;
    // [R14] every reading pulse
    meas_pulse = COND_RST;
    meas_pulse[MEAS_BAT_RDY] = battery_reading_ready_i;
    meas_pulse[MEAS_CHG_RDY] = charger_reading_ready_i;
    ques_cond = COND_RST;
    ques_cond[QUES_CAL_BAD] = cal_bad_ff;
    // [R16] event from power-up capture
    ques_set = COND_RST;
    ques_set[QUES_CAL_BAD] = cal_const_bad_i && !init_done_ff;
  end

  always_comb begin
    std_set = EVT_RST;
    std_set[STD_OP_DONE] = opc_set;
    // [R2] empty queue read
    std_set[STD_QUERY_ERR] = query_empty_read_i;
    // [R3] internal failure
    std_set[STD_DEV_ERR] = device_fault_i;
    // [R4] execution failure
    std_set[STD_EXEC_ERR] = exec_fault_i;
    // [R5] command error sources
    std_set[STD_CMD_ERR] = syntax_err_i || semantic_err_i || trigger_in_msg_i;
    // [R6] local key
    std_set[STD_USER_REQ] = local_key_i;
    // [R7] power-on after reset
    std_set[STD_POWER_ON] = !init_done_ff;
  end

  assign is_cmd_cls = cmd_valid_i && cmd_op_i == OP_CLEAR_STATUS;
  assign is_read_evt = cmd_valid_i && cmd_op_i == OP_READ_EVT;

  // [R19] rising conditions latch as events
  assign std_if.set_vec = std_set;
  assign oper_if.set_vec = nxt_oper_cond & ~oper_cond_ff;
  assign meas_if.set_vec = (nxt_meas_cond & ~meas_cond_ff) | meas_pulse;
  assign ques_if.set_vec = ques_set;
  // [R20] read and clear-status
  assign std_if.rd_clr = is_read_evt && cmd_set_i == SET_STD;
  assign oper_if.rd_clr = is_read_evt && cmd_set_i == SET_OPER;
  assign meas_if.rd_clr = is_read_evt && cmd_set_i == SET_MEAS;
  assign ques_if.rd_clr = is_read_evt && cmd_set_i == SET_QUES;
  assign std_if.cls = is_cmd_cls;
  assign oper_if.cls = is_cmd_cls;
  assign meas_if.cls = is_cmd_cls;
  assign ques_if.cls = is_cmd_cls;
  assign std_if.en_wr = cmd_valid_i && cmd_op_i == OP_WRITE_EN && cmd_set_i == SET_STD;
  assign oper_if.en_wr = cmd_valid_i && cmd_op_i == OP_WRITE_EN && cmd_set_i == SET_OPER;
  assign meas_if.en_wr = cmd_valid_i && cmd_op_i == OP_WRITE_EN && cmd_set_i == SET_MEAS;
  assign ques_if.en_wr = cmd_valid_i && cmd_op_i == OP_WRITE_EN && cmd_set_i == SET_QUES;
  assign std_if.en_clr = 1'b0;
  assign oper_if.en_clr = cmd_valid_i && cmd_op_i == OP_PRESET;
  assign meas_if.en_clr = cmd_valid_i && cmd_op_i == OP_PRESET;
  assign ques_if.en_clr = cmd_valid_i && cmd_op_i == OP_PRESET;
  assign std_if.en_data = cmd_data_i;
  assign oper_if.en_data = cmd_data_i;
  assign meas_if.en_data = cmd_data_i;
  assign ques_if.en_data = cmd_data_i;

  always_comb begin
    nxt_rsp_valid = cmd_valid_i && (cmd_op_i == OP_READ_EVT || cmd_op_i == OP_READ_COND || cmd_op_i == OP_READ_EN);
    nxt_rsp_data = rsp_data_ff;
    if (nxt_rsp_valid) begin
      nxt_rsp_data = COND_RST;
      unique case (cmd_set_i)
        SET_STD: begin
          // [R17] no standard condition
          if (cmd_op_i == OP_READ_EVT) nxt_rsp_data = std_if.evt;
          if (cmd_op_i == OP_READ_EN) nxt_rsp_data = std_if.en;
        end
        SET_OPER: begin
          if (cmd_op_i == OP_READ_EVT) nxt_rsp_data = oper_if.evt;
          if (cmd_op_i == OP_READ_COND) nxt_rsp_data = oper_cond_ff;
          if (cmd_op_i == OP_READ_EN) nxt_rsp_data = oper_if.en;
        end
        SET_MEAS: begin
          if (cmd_op_i == OP_READ_EVT) nxt_rsp_data = meas_if.evt;
          if (cmd_op_i == OP_READ_COND) nxt_rsp_data = meas_cond_ff;
          if (cmd_op_i == OP_READ_EN) nxt_rsp_data = meas_if.en;
        end
        SET_QUES: begin
          if (cmd_op_i == OP_READ_EVT) nxt_rsp_data = ques_if.evt;
          if (cmd_op_i == OP_READ_COND) nxt_rsp_data = ques_cond;
          if (cmd_op_i == OP_READ_EN) nxt_rsp_data = ques_if.en;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      opc_state_ff <= OPC_IDLE;
      init_done_ff <= 1'b0;
      cal_bad_ff <= 1'b0;
      oper_cond_ff <= COND_RST;
      meas_cond_ff <= COND_RST;
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= COND_RST;
    end else begin
      opc_state_ff <= nxt_opc_state;
      init_done_ff <= 1'b1;
      cal_bad_ff <= nxt_cal_bad;
      oper_cond_ff <= nxt_oper_cond;
      meas_cond_ff <= nxt_meas_cond;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff <= nxt_rsp_data;
    end
  end

  assign rsp_valid_o = rsp_valid_ff;
  assign rsp_data_o = rsp_data_ff;
  // [R21] per-set summaries
  assign std_summary_o = std_if.summary;
  assign oper_summary_o = oper_if.summary;
  assign meas_summary_o = meas_if.summary;
  assign ques_summary_o = ques_if.summary;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_OPC_ONLY_CMD: assert property ($rose(std_if.evt[STD_OP_DONE]) |-> $past(opc_state_ff == OPC_WAIT && !ops_pending_i)) // [R1]
    else $error("operation done set without command");
  AST_QUERY_ERR: assert property (query_empty_read_i |=> std_if.evt[STD_QUERY_ERR]) // [R2]
    else $error("query error missed");
  AST_DEV_ERR: assert property (device_fault_i |=> std_if.evt[STD_DEV_ERR]) // [R3]
    else $error("device error missed");
  AST_EXEC_ERR: assert property (exec_fault_i |=> std_if.evt[STD_EXEC_ERR]) // [R4]
    else $error("execution error missed");
  AST_CMD_ERR: assert property (syntax_err_i || semantic_err_i || trigger_in_msg_i |=> std_if.evt[STD_CMD_ERR]) // [R5]
    else $error("command error missed");
  AST_USER_REQ: assert property (local_key_i |=> std_if.evt[STD_USER_REQ]) // [R6]
    else $error("user request missed");
  AST_POWER_ON: assert property (!init_done_ff |-> std_if.evt[STD_POWER_ON]) // [R7]
    else $error("power-on bit missing after reset");
  AST_VPROT: assert property ($rose(charger_overvolt_protect_i) |=> oper_if.evt[OPER_CHG_VPROT]) // [R8]
    else $error("voltage protection event missed");
  AST_CLIM_LIVE: assert property (##1 oper_cond_ff[OPER_CHG_CLIM] == $past(charger_in_current_limit_i)) // [R9]
    else $error("current limit state wrong");
  AST_TRIP_CLEAR: assert property (battery_output_on_i && !battery_limit_trip_i |=> !oper_cond_ff[OPER_BAT_TRIP]) // [R10]
    else $error("trip not cleared on re-enable");
  AST_HOT: assert property ($rose(main_supply_overheat_off_i) |=> oper_if.evt[OPER_SUPPLY_HOT]) // [R11]
    else $error("supply overheat event missed");
  AST_OVF: assert property ($rose(battery_reading_overflow_i) |=> meas_if.evt[MEAS_BAT_OVF]) // [R12]
    else $error("overflow event missed");
  AST_PTO: assert property ($rose(charger_pulse_timeout_i) |=> meas_if.evt[MEAS_CHG_PTO]) // [R13]
    else $error("pulse timeout event missed");
  AST_RDY: assert property (charger_reading_ready_i |=> meas_if.evt[MEAS_CHG_RDY]) // [R14]
    else $error("reading ready event missed");
  AST_BUF: assert property ($rose(buf_full_ff[CH_BAT]) |-> meas_if.evt[MEAS_BAT_BUF]) // [R15]
    else $error("buffer full event missed");
  AST_CAL: assert property (init_done_ff && cal_done_ok_i |=> !ques_cond[QUES_CAL_BAD]) // [R16]
    else $error("calibration flag not cleared");
  AST_PTO_LIVE: assert property (##1 meas_cond_ff[MEAS_BAT_PTO] == $past(battery_pulse_timeout_i)) // [R18]
    else $error("pulse timeout condition wrong");
  AST_RSP_UNUSED: assert property (rsp_valid_ff |-> (oper_cond_ff & ~OPER_USED_MASK) == '0 && (meas_cond_ff & ~MEAS_USED_MASK) == '0) // [R22]
    else $error("unused condition bit set");
  COV_OPC: cover property (opc_state_ff == OPC_WAIT ##1 opc_state_ff == OPC_IDLE);
  COV_BUF_FULL: cover property ($rose(buf_full_ff[CH_CHG]));
  COV_READ_CLR: cover property (is_read_evt && cmd_set_i == SET_MEAS && meas_if.evt != '0);
endmodule // ses_status_top

// File: shared/ses_evt_if.sv
`timescale 1ns/1ns
interface ses_evt_if;
  import ses_pkg::*;
  logic [REG_W-1:0] set_vec;
  logic [REG_W-1:0] en_data;
  logic [REG_W-1:0] evt;
  logic [REG_W-1:0] en;
  logic rd_clr;
  logic cls;
  logic en_wr;
  logic en_clr;
  logic summary;
  modport ctl (output set_vec, rd_clr, cls, en_wr, en_clr, en_data, input evt, en, summary);
  modport bank (input set_vec, rd_clr, cls, en_wr, en_clr, en_data, output evt, en, summary);
endinterface

// File: shared/ses_pkg.sv
package ses_pkg;
  localparam int REG_W = 16;
  localparam int N_CHAN = 2;
  localparam int CH_BAT = 0;
  localparam int CH_CHG = 1;
  localparam int AVG_CNT_W = 8;
  // standard event positions
  localparam int STD_OP_DONE = 0;
  localparam int STD_QUERY_ERR = 2;
  localparam int STD_DEV_ERR = 3;
  localparam int STD_EXEC_ERR = 4;
  localparam int STD_CMD_ERR = 5;
  localparam int STD_USER_REQ = 6;
  localparam int STD_POWER_ON = 7;
  // operation positions
  localparam int OPER_BAT_VPROT = 1;
  localparam int OPER_CHG_VPROT = 2;
  localparam int OPER_BAT_CLIM = 3;
  localparam int OPER_BAT_TRIP = 4;
  localparam int OPER_STAGE_HOT = 5;
  localparam int OPER_SUPPLY_HOT = 6;
  localparam int OPER_CHG_CLIM = 7;
  localparam int OPER_CHG_TRIP = 8;
  // measurement positions
  localparam int MEAS_BAT_OVF = 3;
  localparam int MEAS_BAT_PTO = 4;
  localparam int MEAS_BAT_RDY = 5;
  localparam int MEAS_CHG_OVF = 6;
  localparam int MEAS_CHG_PTO = 7;
  localparam int MEAS_CHG_RDY = 8;
  localparam int MEAS_BAT_BUF = 9;
  localparam int MEAS_CHG_BUF = 10;
  // questionable position
  localparam int QUES_CAL_BAD = 8;
  // used-bit masks and reset values
  localparam logic [REG_W-1:0] STD_USED_MASK = 16'h00fd;
  localparam logic [REG_W-1:0] OPER_USED_MASK = 16'h01fe;
  localparam logic [REG_W-1:0] MEAS_USED_MASK = 16'h07f8;
  localparam logic [REG_W-1:0] QUES_USED_MASK = 16'h0100;
  localparam logic [REG_W-1:0] STD_EVT_RST = 16'h0080;
  localparam logic [REG_W-1:0] EVT_RST = 16'h0000;
  localparam logic [REG_W-1:0] EN_RST = 16'h0000;
  localparam logic [REG_W-1:0] COND_RST = 16'h0000;

  typedef enum logic [2:0] {
    OP_READ_EVT,
    OP_READ_COND,
    OP_READ_EN,
    OP_WRITE_EN,
    OP_CLEAR_STATUS,
    OP_PRESET,
    OP_OPC
  } ses_op_t;

  typedef enum logic [1:0] {
    SET_STD,
    SET_OPER,
    SET_MEAS,
    SET_QUES
  } ses_set_t;

  typedef enum logic {
    OPC_IDLE,
    OPC_WAIT
  } ses_opc_state_t;
endpackage

// File: verification/ses_host_model.sv
`timescale 1ns/1ns
// remote host: one command per call, fields held across the taking edge
module ses_host_model (
  input wire logic sys_clk_i,
  input wire logic rsp_valid_i,
  input wire logic [ses_pkg::REG_W-1:0] rsp_data_i,
  output logic cmd_valid_o,
  output ses_pkg::ses_op_t cmd_op_o,
  output ses_pkg::ses_set_t cmd_set_o,
  output logic [ses_pkg::REG_W-1:0] cmd_data_o
);
  import ses_pkg::*;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_op_o = OP_READ_EVT;
    cmd_set_o = SET_STD;
    cmd_data_o = 16'h0000;
  end
  task automatic send(input ses_op_t op, input ses_set_t st, input logic [REG_W-1:0] dat);
    @(posedge sys_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_op_o <= op;
    cmd_set_o <= st;
    cmd_data_o <= dat;
    @(posedge sys_clk_i);
    cmd_valid_o <= 1'b0;
  endtask
  // bounded wait for the answer pulse
  task automatic query(input ses_op_t op, input ses_set_t st, output logic [REG_W-1:0] dat, output logic ok);
    int i;
    ok = 1'b0;
    dat = 16'h0000;
    send(op, st, 16'h0000);
    for (i = 0; i < 3 && !ok; i++) begin
      #1;
      if (rsp_valid_i === 1'b1) begin
        ok = 1'b1;
        dat = rsp_data_i;
      end else begin
        @(posedge sys_clk_i);
      end
    end
  endtask
endmodule // ses_host_model

// File: verification/tb.sv
`timescale 1ns/1ns
module tb;
  import ses_pkg::*;
  logic sys_clk_i;
  logic sys_rst_i;
  logic [26:0] ev;
  logic [7:0] bat_avg;
  logic cal_bad;
  logic cmd_valid;
  ses_op_t cmd_op;
  ses_set_t cmd_set;
  logic [15:0] cmd_data;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic [3:0] summ;
  logic [15:0] d;
  logic ok;
  ses_set_t st;
  int fails;
  int n_checks;
  logic [15:0] exp_tab [21] = '{16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0020, 16'h0020, 16'h0040,
    16'h0002, 16'h0004, 16'h0008, 16'h0080, 16'h0010, 16'h0100, 16'h0020, 16'h0040,
    16'h0008, 16'h0040, 16'h0010, 16'h0080, 16'h0020, 16'h0100};
  ses_status_top u_ses_status_top (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid),
    .cmd_op_i(cmd_op), .cmd_set_i(cmd_set), .cmd_data_i(cmd_data), .ops_pending_i(ev[26]),
    .query_empty_read_i(ev[0]), .device_fault_i(ev[1]), .exec_fault_i(ev[2]), .syntax_err_i(ev[3]),
    .semantic_err_i(ev[4]), .trigger_in_msg_i(ev[5]), .local_key_i(ev[6]),
    .battery_overvolt_protect_i(ev[7]), .charger_overvolt_protect_i(ev[8]),
    .battery_in_current_limit_i(ev[9]), .charger_in_current_limit_i(ev[10]),
    .battery_limit_trip_i(ev[11]), .charger_limit_trip_i(ev[12]),
    .output_stage_overheat_off_i(ev[13]), .main_supply_overheat_off_i(ev[14]),
    .battery_reading_overflow_i(ev[15]), .charger_reading_overflow_i(ev[16]),
    .battery_pulse_timeout_i(ev[17]), .charger_pulse_timeout_i(ev[18]),
    .battery_reading_ready_i(ev[19]), .charger_reading_ready_i(ev[20]),
    .battery_output_on_i(ev[21]), .charger_output_on_i(ev[22]),
    .battery_buffer_arm_i(ev[23]), .charger_buffer_arm_i(ev[24]), .cal_done_ok_i(ev[25]),
    .battery_avg_count_i(bat_avg), .charger_avg_count_i(8'hff), .cal_const_bad_i(cal_bad),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .std_summary_o(summ[0]), .oper_summary_o(summ[1]),
    .meas_summary_o(summ[2]), .ques_summary_o(summ[3]));
  ses_host_model u_ses_host_model (.sys_clk_i(sys_clk_i), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data),
    .cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op), .cmd_set_o(cmd_set), .cmd_data_o(cmd_data));
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task automatic conclude();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input ses_op_t op, input ses_set_t s);
    u_ses_host_model.query(op, s, d, ok);
    if (ok !== 1'b1) begin
      fails++;
      conclude();
    end
  endtask
  task automatic pulse(input int i);
    @(posedge sys_clk_i);
    ev[i] <= 1'b1;
    @(posedge sys_clk_i);
    ev[i] <= 1'b0;
  endtask
  initial begin
    sys_rst_i = 1'b1;
    ev = '0;
    bat_avg = 8'hff;
    cal_bad = 1'b1;
    fails = 0;
    n_checks = 0;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rd(OP_READ_EVT, SET_STD);
    chk("std evt", d, 16'h0080);
    u_ses_host_model.send(OP_WRITE_EN, SET_QUES, 16'h0100);
    #1;
    chk("ques sum", {15'h0000, summ[3]}, 16'h0001);
    rd(OP_READ_EVT, SET_QUES);
    chk("ques evt", d, 16'h0100);
    chk("ques sum", {15'h0000, summ[3]}, 16'h0000);
    rd(OP_READ_COND, SET_QUES);
    chk("ques cond", d, 16'h0100);
    cal_bad <= 1'b0;
    pulse(25);
    rd(OP_READ_COND, SET_QUES);
    chk("ques cond", d, 16'h0000);
    rd(OP_READ_COND, SET_STD);
    chk("std cond", d, 16'h0000);
    for (int i = 0; i < 21; i++) begin
      st = (i < 7) ? SET_STD : (i < 15) ? SET_OPER : SET_MEAS;
      pulse(i);
      rd(OP_READ_EVT, st);
      chk("row evt", d, exp_tab[i]);
      rd(OP_READ_EVT, st);
      chk("row clr", d, 16'h0000);
    end
    rd(OP_READ_COND, SET_OPER);
    chk("trip cond", d, 16'h0110);
    pulse(21);
    pulse(22);
    rd(OP_READ_COND, SET_OPER);
    chk("trip cond", d, 16'h0000);
    @(posedge sys_clk_i);
    ev[9] <= 1'b1;
    ev[10] <= 1'b1;
    ev[17] <= 1'b1;
    rd(OP_READ_COND, SET_OPER);
    chk("clim cond", d, 16'h0088);
    rd(OP_READ_COND, SET_MEAS);
    chk("pto cond", d, 16'h0010);
    ev[9] <= 1'b0;
    ev[10] <= 1'b0;
    ev[17] <= 1'b0;
    rd(OP_READ_COND, SET_OPER);
    chk("clim cond", d, 16'h0000);
    rd(OP_READ_COND, SET_MEAS);
    chk("pto cond", d, 16'h0000);
    rd(OP_READ_EVT, SET_OPER);
    chk("clim evt", d, 16'h0088);
    bat_avg <= 8'h03;
    pulse(23);
    pulse(19);
    pulse(19);
    rd(OP_READ_EVT, SET_MEAS);
    chk("buf evt", d, 16'h0030);
    pulse(19);
    u_ses_host_model.send(OP_WRITE_EN, SET_MEAS, 16'h0200);
    #1;
    chk("meas sum", {15'h0000, summ[2]}, 16'h0001);
    rd(OP_READ_EVT, SET_MEAS);
    chk("buf evt", d, 16'h0220);
    u_ses_host_model.send(OP_WRITE_EN, SET_OPER, 16'hffff);
    rd(OP_READ_EN, SET_OPER);
    chk("oper en", d, 16'h01fe);
    pulse(13);
    @(posedge sys_clk_i);
    #1;
    chk("oper sum", {15'h0000, summ[1]}, 16'h0001);
    rd(OP_READ_EVT, SET_OPER);
    chk("oper evt", d, 16'h0020);
    chk("oper sum", {15'h0000, summ[1]}, 16'h0000);
    u_ses_host_model.send(OP_PRESET, SET_STD, 16'h0000);
    rd(OP_READ_EN, SET_OPER);
    chk("oper en", d, 16'h0000);
    @(posedge sys_clk_i);
    ev[26] <= 1'b1;
    u_ses_host_model.send(OP_OPC, SET_STD, 16'h0000);
    repeat (3) @(posedge sys_clk_i);
    rd(OP_READ_EVT, SET_STD);
    chk("opc wait", d, 16'h0000);
    ev[26] <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    u_ses_host_model.send(OP_WRITE_EN, SET_STD, 16'h0001);
    #1;
    chk("std sum", {15'h0000, summ[0]}, 16'h0001);
    rd(OP_READ_EVT, SET_STD);
    chk("opc done", d, 16'h0001);
    pulse(6);
    u_ses_host_model.send(OP_CLEAR_STATUS, SET_STD, 16'h0000);
    rd(OP_READ_EVT, SET_STD);
    chk("cls evt", d, 16'h0000);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rd(OP_READ_EVT, SET_STD);
    chk("std evt", d, 16'h0080);
    rd(OP_READ_EVT, SET_QUES);
    chk("ques evt", d, 16'h0000);
    conclude();
  end
endmodule // tb
